// *** core/fhm_pkg.sv ***
// Purpose: shared constants and types of the fault handling manager and its host end
// Assumes: one clock, core_clk at 125 MHz, synchronous active-high reset
// Notes: fault indices below address the status and configuration vectors
package fhm_pkg;
	localparam int unsigned CLK_MHZ = 125;
	localparam real RELEASE_LOW_MINIMUM_US = 2.5;
	localparam int unsigned RELEASE_LOW_CYCLES = int'($ceil(RELEASE_LOW_MINIMUM_US * CLK_MHZ));
	localparam int unsigned NUM_BRIDGES = 3;
	localparam int unsigned NUM_CFG_FAULTS = 13;
	// configurable fault indices: 0..2 shoot-through, 3..5 high short, 6..8 low short
	localparam int unsigned IDX_SHOOT = 0;
	localparam int unsigned IDX_HS_SHORT = 3;
	localparam int unsigned IDX_LS_SHORT = 6;
	localparam int unsigned IDX_MOTOR_UV = 9;
	localparam int unsigned IDX_MOTOR_OV = 10;
	localparam int unsigned IDX_BOOT_UV = 11;
	localparam int unsigned IDX_BOOT_OV = 12;
	// fixed-reaction fault indices in the fixed status vector
	localparam int unsigned NUM_FIX_FAULTS = 10;
	localparam int unsigned FIX_PRE_UV = 0;
	localparam int unsigned FIX_PRE_OV = 1;
	localparam int unsigned FIX_PUMP_UV = 2;
	localparam int unsigned FIX_PUMP_OV = 3;
	localparam int unsigned FIX_WD_DATA = 4;
	localparam int unsigned FIX_WD_TIMEOUT = 5;
	localparam int unsigned FIX_NVM_CRC = 6;
	localparam int unsigned FIX_CFG_CRC = 7;
	localparam int unsigned FIX_SELF_TEST = 8;
	localparam int unsigned FIX_SERIAL = 9;
	localparam logic [1:0] REACT_SHUTDOWN = 2'h0;
	localparam logic [1:0] REACT_REDUCED = 2'h1;
	localparam logic [1:0] REACT_RESET = 2'h0;
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_GONE = 2'h2;
	localparam logic [1:0] ERR_FAULT = 2'h3;
	localparam logic FAULT_PIN_DRIVE_RESET = 1'b0;
	localparam logic MASK_RESET = 1'b0;
	typedef enum logic [2:0] {
		FHM_NORMAL = 3'h1,
		FHM_SAFE_OFF = 3'h2,
		FHM_WAIT_EDGE = 3'h4
	} fhm_mode_t;
	typedef enum logic [2:0] {
		FHM_H_IDLE = 3'h1,
		FHM_H_LOW = 3'h2,
		FHM_H_DONE = 3'h4
	} fhm_host_t;
endpackage

// *** core/fhm_link_if.sv ***
// Purpose: join of the fault handling device and its host controller
// Assumes: same clock on both ends; fault pin resolved here from enables
// Notes: fault pin output enable is low while driven
interface fhm_link_if;
	import fhm_pkg::*;
	logic bridge_enable_pin;
	logic fault_out;
	logic fault_oe_n;
	logic fault_output_pin;
	logic [1:0] frame_error_field;
	logic frame_valid;
	logic frame_bad;
	logic cfg_mode;
	logic cfg_we;
	logic [2*NUM_CFG_FAULTS-1:0] cfg_reaction;
	logic [NUM_CFG_FAULTS-1:0] cfg_mask;
	logic cfg_drive_select;
	logic [NUM_CFG_FAULTS-1:0] rd_cfg_clear;
	logic [NUM_FIX_FAULTS-1:0] rd_fix_clear;
	logic [NUM_CFG_FAULTS-1:0] cfg_status;
	logic [NUM_FIX_FAULTS-1:0] fix_status;
	// open-drain pulls up when not driven
	assign fault_output_pin = fault_oe_n ? 1'b1 : fault_out;
	modport device (input bridge_enable_pin, output fault_out, output fault_oe_n,
		output frame_error_field, input frame_valid, input frame_bad, input cfg_mode,
		input cfg_we, input cfg_reaction, input cfg_mask, input cfg_drive_select,
		input rd_cfg_clear, input rd_fix_clear, output cfg_status, output fix_status);
	modport host (output bridge_enable_pin, input fault_output_pin,
		input frame_error_field, output frame_valid, output frame_bad, output cfg_mode,
		output cfg_we, output cfg_reaction, output cfg_mask, output cfg_drive_select,
		output rd_cfg_clear, output rd_fix_clear, input cfg_status, input fix_status);
endinterface

// *** core/fhm_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: reset value is a constant
// Notes: first stage is read only by the second
module fhm_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			stage1 <= '0;
			dout <= '0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule

// *** core/fhm_device.sv ***
// Purpose: fault handling manager of a three-phase gate driver
// Assumes: fault detectors deliver levels from other domains; bridge enable pin is asynchronous
// Notes: bridge/pump disable outputs are level outputs, registered
// Function
// [R1] predriver undervolt retries, overvolt shuts down
// [R2] pump supply faults only raise flags
// [R3] motor and boot faults use reaction fields
// [R4] bad frame sets serial flag, frame dropped
// [R5] configuration written only in configuration mode
// [R6] two-bit field selects shutdown, reduced, warning
// [R7] reduced operation only for bridge faults
// [R8] supply faults treat code 01 as warning
// [R9] drive select: push-pull or open-drain
// [R10] unmasked shutdown fault drives pin low, error
// [R11] fault gone: pin high, error field 10
// [R12] error field 11 alone means shutdown fault
// [R13] mask bit suppresses pin and field reporting
// [R14] priority shutdown, retry, reduced, warning
// [R15] shutdown sets flag, field 11, pin low
// [R16] full shutdown disables bridges and pumps
// [R17] software disable bits stay untouched
// [R18] status flag clears on read
// [R19] exit: fault gone, flag read, enable pulse
// [R20] host holds enable low 2.5 us
// [R21] retry fault tristates bridges, stays normal
// [R22] warning sets flag only
// [R23] watchdog, crc, self-test faults force shutdown
module fhm_device
	import fhm_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	fhm_link_if.device link,
	input wire logic [NUM_CFG_FAULTS-1:0] cfg_fault_raw,
	input wire logic [NUM_FIX_FAULTS-2:0] fix_fault_raw,
	input wire logic [NUM_BRIDGES-1:0] sw_bridge_disable,
	input wire logic sw_pump_enable,
	output logic [NUM_BRIDGES-1:0] bridge_off,
	output logic pump_off,
	output logic load_defaults,
	output logic frame_accept
);
	logic [NUM_CFG_FAULTS-1:0] cfg_fault;
	logic [NUM_FIX_FAULTS-2:0] fix_fault;
	logic en_pin;
	logic en_pin_d;
	logic [2*NUM_CFG_FAULTS-1:0] reaction;
	logic [2*NUM_CFG_FAULTS-1:0] next_reaction;
	logic [NUM_CFG_FAULTS-1:0] mask;
	logic [NUM_CFG_FAULTS-1:0] next_mask;
	logic drive_sel;
	logic next_drive_sel;
	logic [NUM_CFG_FAULTS-1:0] cfg_flag;
	logic [NUM_CFG_FAULTS-1:0] next_cfg_flag;
	logic [NUM_FIX_FAULTS-1:0] fix_flag;
	logic [NUM_FIX_FAULTS-1:0] next_fix_flag;
	fhm_mode_t mode;
	fhm_mode_t next_mode;
	logic [NUM_BRIDGES-1:0] reduced_lat;
	logic [NUM_BRIDGES-1:0] next_reduced_lat;
	logic [1:0] err;
	logic [1:0] next_err;
	logic pin_low;
	logic next_pin_low;
	logic [NUM_BRIDGES-1:0] next_bridge_off;
	logic next_pump_off;
	logic next_load_defaults;
	logic next_frame_accept;
	logic std_now;
	logic std_report;
	logic retry_now;
	logic [NUM_BRIDGES-1:0] reduced_now;
	logic en_rise;

	fhm_sync #(.WIDTH(NUM_CFG_FAULTS + NUM_FIX_FAULTS)) u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.din({cfg_fault_raw, fix_fault_raw, link.bridge_enable_pin}),
		.dout({cfg_fault, fix_fault, en_pin})
	);

	// shutdown code 00; 01 reduced only for bridge faults, else warning
	function automatic logic is_shutdown(input logic [1:0] code);
		return code == REACT_SHUTDOWN; // [R6]
	endfunction

	always_comb begin
		std_now = 1'b0;
		std_report = 1'b0;
		reduced_now = '0;
		for (int i = 0; i < NUM_CFG_FAULTS; i++) begin
			if (cfg_fault[i] && is_shutdown(reaction[2*i +: 2])) begin // [R3]
				std_now = 1'b1;
				if (!mask[i]) begin
					std_report = 1'b1; // [R13]
				end
			end
			// [R7] [R8] code 01 is a warning outside bridge faults
			if (cfg_fault[i] && reaction[2*i +: 2] == REACT_REDUCED && i < IDX_MOTOR_UV) begin
				reduced_now[i % NUM_BRIDGES] = 1'b1;
			end
		end
		// [R1] [R23] fixed shutdown sources; pump faults absent here [R2]
		if (fix_fault[FIX_PRE_OV] || fix_fault[FIX_WD_DATA] || fix_fault[FIX_WD_TIMEOUT]
			|| fix_fault[FIX_NVM_CRC] || fix_fault[FIX_CFG_CRC] || fix_fault[FIX_SELF_TEST]) begin
			std_now = 1'b1;
			std_report = 1'b1;
		end
		retry_now = fix_fault[FIX_PRE_UV]; // [R1]
		en_rise = en_pin && !en_pin_d;
	end

	// configuration group
	always_comb begin
		next_reaction = reaction;
		next_mask = mask;
		next_drive_sel = drive_sel;
		if (link.cfg_we && link.cfg_mode) begin // [R5]
			next_reaction = link.cfg_reaction;
			next_mask = link.cfg_mask;
			next_drive_sel = link.cfg_drive_select; // [R9]
		end
		if (fix_fault[FIX_NVM_CRC]) begin // [R23]
			next_reaction = {NUM_CFG_FAULTS{REACT_RESET}};
			next_mask = {NUM_CFG_FAULTS{MASK_RESET}};
			next_drive_sel = FAULT_PIN_DRIVE_RESET;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			reaction <= {NUM_CFG_FAULTS{REACT_RESET}};
			mask <= {NUM_CFG_FAULTS{MASK_RESET}};
			drive_sel <= FAULT_PIN_DRIVE_RESET;
		end else begin
			reaction <= next_reaction;
			mask <= next_mask;
			drive_sel <= next_drive_sel;
		end
	end

	// flags: set wins over clear-on-read
	always_comb begin
		next_cfg_flag = (cfg_flag & ~link.rd_cfg_clear) | cfg_fault; // [R18] [R22]
		next_fix_flag = (fix_flag & ~link.rd_fix_clear) | {1'b0, fix_fault}; // [R2] [R15]
		next_fix_flag[FIX_SERIAL] = (fix_flag[FIX_SERIAL] & ~link.rd_fix_clear[FIX_SERIAL])
			| (link.frame_valid & link.frame_bad); // [R4]
		next_frame_accept = link.frame_valid & ~link.frame_bad; // [R4]
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cfg_flag <= '0;
			fix_flag <= '0;
			frame_accept <= 1'b0;
		end else begin
			cfg_flag <= next_cfg_flag;
			fix_flag <= next_fix_flag;
			frame_accept <= next_frame_accept;
		end
	end

	// reaction state
	always_comb begin
		next_mode = mode;
		next_reduced_lat = reduced_lat | reduced_now;
		next_err = err;
		next_pin_low = pin_low;
		unique case (mode)
			FHM_NORMAL: begin
				if (std_now) begin
					next_mode = FHM_SAFE_OFF; // [R14]
				end
			end
			FHM_SAFE_OFF: begin
				// [R19] fault gone and all flags read except the FIX_PRE_UV and FIX_SERIAL flags
				if (!std_now && cfg_flag == '0 && fix_flag[FIX_SELF_TEST:FIX_PRE_OV] == '0
					&& !en_pin) begin
					next_mode = FHM_WAIT_EDGE;
				end
			end
			FHM_WAIT_EDGE: begin
				if (std_now) begin
					next_mode = FHM_SAFE_OFF;
				end else if (en_rise) begin
					next_mode = FHM_NORMAL; // [R19]
				end
			end
		endcase
		if (en_rise && reduced_now == '0) begin
			next_reduced_lat = '0;
		end
		if (std_report) begin
			next_err = ERR_FAULT; // [R10] [R15] [R12]
			next_pin_low = 1'b1;
		end else if (err == ERR_FAULT) begin
			next_err = ERR_GONE; // [R11]
			next_pin_low = 1'b0;
		end
		next_pump_off = (next_mode != FHM_NORMAL) || !sw_pump_enable; // [R16] [R17]
		for (int b = 0; b < NUM_BRIDGES; b++) begin
			// [R21] retry tristates; [R16] shutdown all; [R17] software bit kept apart
			next_bridge_off[b] = (next_mode != FHM_NORMAL) || retry_now || next_reduced_lat[b]
				|| sw_bridge_disable[b] || !en_pin;
		end
		next_load_defaults = fix_fault[FIX_NVM_CRC]; // [R23]
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			mode <= FHM_NORMAL;
			reduced_lat <= '0;
			err <= ERR_NONE;
			pin_low <= 1'b0;
			en_pin_d <= 1'b0;
			bridge_off <= '1;
			pump_off <= 1'b1;
			load_defaults <= 1'b0;
			link.fault_out <= 1'b1;
			link.fault_oe_n <= 1'b0;
		end else begin
			mode <= next_mode;
			reduced_lat <= next_reduced_lat;
			err <= next_err;
			pin_low <= next_pin_low;
			en_pin_d <= en_pin;
			bridge_off <= next_bridge_off;
			pump_off <= next_pump_off;
			load_defaults <= next_load_defaults;
			link.fault_out <= !next_pin_low;
			// open-drain releases the pin rather than driving high
			link.fault_oe_n <= next_drive_sel && !next_pin_low; // [R9]
		end
	end

	assign link.frame_error_field = err;
	assign link.cfg_status = cfg_flag;
	assign link.fix_status = fix_flag;
endmodule

// *** core/fhm_host.sv ***
// Purpose: host controller end: configuration and shutdown release
// Assumes: same clock as the device end
// Notes: release pulse length is a parameter
module fhm_host
	import fhm_pkg::*;
#(
	parameter int unsigned LOW_CYCLES = RELEASE_LOW_CYCLES
) (
	input wire logic core_clk,
	input wire logic srst,
	fhm_link_if.host link,
	input wire logic cfg_mode_req,
	input wire logic cfg_write,
	input wire logic [2*NUM_CFG_FAULTS-1:0] cfg_reaction_in,
	input wire logic [NUM_CFG_FAULTS-1:0] cfg_mask_in,
	input wire logic cfg_drive_in,
	input wire logic release_req,
	input wire logic frame_strobe,
	input wire logic frame_corrupt,
	output logic fault_seen,
	output logic release_done
);
	fhm_host_t st;
	fhm_host_t next_st;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic fault_pin_s;
	logic next_fault_seen;
	logic next_release_done;
	logic next_en;

	fhm_sync #(.WIDTH(1)) u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.din(link.fault_output_pin),
		.dout(fault_pin_s)
	);

	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_en = 1'b1;
		next_release_done = 1'b0;
		next_fault_seen = !fault_pin_s || link.frame_error_field == ERR_FAULT; // [R12]
		unique case (st)
			FHM_H_IDLE: begin
				if (release_req) begin
					next_st = FHM_H_LOW;
					next_cnt = '0;
					next_en = 1'b0;
				end
			end
			FHM_H_LOW: begin
				next_en = 1'b0;
				next_cnt = cnt + 16'h1;
				if (cnt >= 16'(LOW_CYCLES - 1)) begin // [R20] [R19]
					next_st = FHM_H_DONE;
					next_en = 1'b1;
				end
			end
			FHM_H_DONE: begin
				next_release_done = 1'b1;
				next_st = FHM_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= FHM_H_IDLE;
			cnt <= '0;
			fault_seen <= 1'b0;
			release_done <= 1'b0;
			link.bridge_enable_pin <= 1'b0;
			link.cfg_mode <= 1'b0;
			link.cfg_we <= 1'b0;
			link.cfg_reaction <= '0;
			link.cfg_mask <= '0;
			link.cfg_drive_select <= 1'b0;
			link.frame_valid <= 1'b0;
			link.frame_bad <= 1'b0;
			link.rd_cfg_clear <= '0;
			link.rd_fix_clear <= '0;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			fault_seen <= next_fault_seen;
			release_done <= next_release_done;
			link.bridge_enable_pin <= next_en;
			link.cfg_mode <= cfg_mode_req;
			link.cfg_we <= cfg_write && cfg_mode_req; // [R5]
			link.cfg_reaction <= cfg_reaction_in; // [R7]
			link.cfg_mask <= cfg_mask_in;
			link.cfg_drive_select <= cfg_drive_in;
			link.frame_valid <= frame_strobe;
			link.frame_bad <= frame_corrupt;
			// reading all status clears it; done on the release request
			link.rd_cfg_clear <= {NUM_CFG_FAULTS{release_req}}; // [R19]
			link.rd_fix_clear <= {NUM_FIX_FAULTS{release_req}};
		end
	end
endmodule

// *** test/fhm_props.sv ***
// Purpose: link checks between the device and host ends
// Assumes: single clock, srst synchronous active high
// Notes: LOW_CYCLES follows the host instance; drive_sel is the device's stored pin mode
module fhm_props
	import fhm_pkg::*;
#(
	parameter int unsigned LOW_CYCLES = 4
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic bridge_enable_pin,
	input wire logic fault_oe_n,
	input wire logic fault_output_pin,
	input wire logic [1:0] frame_error_field,
	input wire logic drive_sel,
	input wire logic [NUM_CFG_FAULTS-1:0] rd_cfg_clear,
	input wire logic [NUM_FIX_FAULTS-1:0] rd_fix_clear,
	input wire logic [NUM_CFG_FAULTS-1:0] cfg_status,
	input wire logic [NUM_FIX_FAULTS-1:0] fix_status
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned low_cnt;
	int unsigned next_low_cnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// counts sampled low cycles, so a short release pulse is caught at the rising edge
	always_comb begin
		next_low_cnt = bridge_enable_pin ? 0 : low_cnt + 1;
	end
	always_ff @(posedge core_clk) begin
		// reset counts as a long low phase, so the first rise after reset is legal
		low_cnt <= srst ? LOW_CYCLES : next_low_cnt;
	end
	sequence fault_shown;
		frame_error_field == ERR_FAULT && !fault_output_pin;
	endsequence
	sequence gone_shown;
		frame_error_field == ERR_GONE && fault_output_pin;
	endsequence
	err_pin_a: assert property (frame_error_field == ERR_FAULT |-> ##[0:1] !fault_output_pin)
		else $error("error field 11 without low pin");
	pin_err_a: assert property ($fell(fault_output_pin) |-> ##[0:1] fault_shown)
		else $error("pin low without error field 11");
	rise_gone_a: assert property ($rose(fault_output_pin) |-> ##[0:1] gone_shown)
		else $error("pin release without error field 10");
	gone_hold_a: assert property (frame_error_field == ERR_GONE |=> frame_error_field[1])
		else $error("error field left 10 without a fault");
	err_code_a: assert property (frame_error_field != 2'h1)
		else $error("error field shows 01");
	open_drain_a: assert property (
		drive_sel && $past(drive_sel) && fault_output_pin |-> fault_oe_n)
		else $error("open-drain pin driven high");
	push_pull_a: assert property (!drive_sel && !$past(drive_sel) |-> !fault_oe_n)
		else $error("push-pull pin not driven");
	cfg_sticky_a: assert property (
		($past(cfg_status) & ~cfg_status & ~$past(rd_cfg_clear)) == '0)
		else $error("fault flag dropped without read");
	fix_sticky_a: assert property (
		($past(fix_status) & ~fix_status & ~$past(rd_fix_clear)) == '0)
		else $error("fixed flag dropped without read");
	low_time_a: assert property ($rose(bridge_enable_pin) |-> low_cnt >= LOW_CYCLES)
		else $error("enable pin low too short");
endmodule

// *** test/tb_top.sv ***
// Purpose: self-checking bench for the device and host ends joined by the link
// Assumes: release pulse shortened to 4 cycles
// Notes: expectations follow the reaction settings the bench itself wrote
module tb_top
	import fhm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned LOW = 4;
	logic core_clk, srst, pump_en, cfg_mode_req, cfg_write, cfg_drive_in, release_req;
	logic frame_strobe, frame_corrupt, pump_off, load_defaults, frame_accept, release_done;
	logic cur_drv, pin, oe_n, fault_seen;
	logic [1:0] err_f;
	logic [12:0] cfg_raw, cfg_mask_in, cur_mask, cst;
	logic [8:0] fix_raw;
	logic [9:0] fst;
	logic [2:0] sw_dis, bridge_off;
	logic [25:0] cfg_reaction_in, cur_react, r;
	int err_total, checked, seed, acc_cnt;
	fhm_link_if fhm_link_if_inst ();
	assign err_f = fhm_link_if_inst.frame_error_field;
	assign pin = fhm_link_if_inst.fault_output_pin;
	assign oe_n = fhm_link_if_inst.fault_oe_n;
	assign cst = fhm_link_if_inst.cfg_status;
	assign fst = fhm_link_if_inst.fix_status;
	fhm_device fhm_device_inst (.core_clk(core_clk), .srst(srst), .link(fhm_link_if_inst),
		.cfg_fault_raw(cfg_raw), .fix_fault_raw(fix_raw), .sw_bridge_disable(sw_dis),
		.sw_pump_enable(pump_en), .bridge_off(bridge_off), .pump_off(pump_off),
		.load_defaults(load_defaults), .frame_accept(frame_accept));
	fhm_host #(.LOW_CYCLES(LOW)) fhm_host_inst (.core_clk(core_clk), .srst(srst),
		.link(fhm_link_if_inst), .cfg_mode_req(cfg_mode_req), .cfg_write(cfg_write),
		.cfg_reaction_in(cfg_reaction_in), .cfg_mask_in(cfg_mask_in), .cfg_drive_in(cfg_drive_in),
		.release_req(release_req), .frame_strobe(frame_strobe), .frame_corrupt(frame_corrupt),
		.fault_seen(fault_seen), .release_done(release_done));
	fhm_props #(.LOW_CYCLES(LOW)) fhm_props_inst (.core_clk(core_clk), .srst(srst),
		.bridge_enable_pin(fhm_link_if_inst.bridge_enable_pin), .fault_oe_n(oe_n),
		.fault_output_pin(pin), .frame_error_field(err_f),
		.drive_sel(fhm_device_inst.drive_sel),
		.rd_cfg_clear(fhm_link_if_inst.rd_cfg_clear), .rd_fix_clear(fhm_link_if_inst.rd_fix_clear),
		.cfg_status(cst), .fix_status(fst));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (frame_accept === 1'b1) acc_cnt++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// only writes made in configuration mode update what the bench expects
	task automatic write_cfg(input logic mode, input logic [25:0] rv, input logic [12:0] m,
		input logic d);
		cfg_mode_req = mode;
		cfg_write = 1'b1;
		cfg_reaction_in = rv;
		cfg_mask_in = m;
		cfg_drive_in = d;
		cyc(1);
		cfg_write = 1'b0;
		cyc(1);
		cfg_mode_req = 1'b0;
		cyc(2);
		if (mode) begin
			cur_react = rv;
			cur_mask = m;
			cur_drv = d;
		end
	endtask
	task automatic release_bridges();
		int n;
		n = 0;
		release_req = 1'b1;
		cyc(1);
		release_req = 1'b0;
		while (release_done !== 1'b1 && n < 50) begin
			cyc(1);
			n++;
		end
		chk(n < 50, 1'b1);
		cyc(6);
	endtask
	function automatic void expect_of(input logic [12:0] c, input logic [8:0] f,
		output logic [2:0] br, output logic pmp, output logic rep, output logic known);
		logic sd;
		logic [2:0] red;
		sd = f[1] | (|f[8:4]);
		rep = sd;
		red = 3'h0;
		for (int i = 0; i < 13; i++) begin
			if (c[i] && cur_react[2*i+:2] == 2'h0) begin
				sd = 1'b1;
				rep = rep | !cur_mask[i];
			end
			if (c[i] && cur_react[2*i+:2] == 2'h1 && i < 9) red[i%3] = 1'b1;
		end
		br = (sd | f[0]) ? 3'h7 : (red | sw_dis);
		pmp = sd | !pump_en;
		known = rep | !(f[0] | (|red));
	endfunction
	task automatic run_case(input logic [12:0] c, input logic [8:0] f);
		logic [2:0] br;
		logic pmp, rep, known;
		expect_of(c, f, br, pmp, rep, known);
		cfg_raw = c;
		fix_raw = f;
		cyc(6);
		chk(bridge_off, br);
		chk(pump_off, pmp);
		chk(cst, c);
		chk(fst[8:0], f);
		chk(load_defaults, f[6]);
		if (known) chk(err_f == ERR_FAULT, rep);
		if (known) chk(pin, !rep);
		if (known) chk(fault_seen, rep);
		cfg_raw = '0;
		fix_raw = '0;
		cyc(6);
		if (rep) chk(err_f, ERR_GONE);
		if (!f[0]) chk(bridge_off, br);
		chk(cst, c);
		release_bridges();
		chk(bridge_off, sw_dis);
		chk({cst, fst}, 23'h0);
		chk(oe_n, cur_drv);
		$display("case c=%h f=%h done", c, f);
	endtask
	task automatic frame(input logic bad);
		int a;
		a = acc_cnt;
		frame_strobe = 1'b1;
		frame_corrupt = bad;
		cyc(1);
		frame_strobe = 1'b0;
		cyc(5);
		chk(acc_cnt - a, !bad);
		chk(fst[FIX_SERIAL], bad);
		$display("frame bad=%0d done", bad);
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, 0, 1);
		summarize();
	end
	initial begin
		{srst, err_total, checked, acc_cnt, seed} = {1'b1, 96'h0, 32'h2ea3};
		{cfg_raw, fix_raw, sw_dis, cfg_mode_req, cfg_write, cfg_drive_in} = '0;
		{cfg_reaction_in, cfg_mask_in, release_req, frame_strobe, frame_corrupt} = '0;
		{cur_react, cur_mask, cur_drv} = '0;
		pump_en = 1'b1;
		repeat (16) @(negedge core_clk);
		srst = 1'b0;
		cyc(2);
		chk({err_f, pin, oe_n}, 4'h2);
		release_bridges();
		chk(bridge_off, 3'h0);
		run_case(13'h0200, 9'h0);
		for (int j = 0; j < 9; j++) run_case(13'h0, 9'h1 << j);
		frame(1'b0);
		frame(1'b1);
		release_bridges();
		write_cfg(1'b0, 26'h3ffffff, 13'h1fff, 1'b1);
		run_case(13'h0001, 9'h0);
		r = 26'h2aaaaaa;
		r[1:0] = 2'h1;
		r[19:18] = 2'h1;
		r[21:20] = 2'h0;
		write_cfg(1'b1, r, 13'h0400, 1'b1);
		run_case(13'h0001, 9'h0);
		run_case(13'h0200, 9'h0);
		run_case(13'h0400, 9'h0);
		run_case(13'h0401, 9'h004);
		run_case(13'h0201, 9'h001);
		for (int k = 0; k < 24; k++) begin
			write_cfg(1'b1, 26'($random(seed)), 13'($random(seed)), 1'($random(seed)));
			sw_dis = 3'($random(seed));
			pump_en = 1'($random(seed));
			run_case(13'($random(seed) & $random(seed)),
				9'($random(seed) & $random(seed) & $random(seed) & 9'h1bf));
		end
		summarize();
	end
endmodule
